// ==== verilog/mrt_tracker.sv ====
// mrt_tracker: maintenance access tracker behind an AXI4-Lite slave
// assumes user logic is the AXI4-Lite master on clk_i (log clock)
// Behaviour
// R1: only 32-bit word accesses accepted
// R2: one read and one write outstanding
// R3: mismatched response tags dropped silently
// R4: dedicated port reset input for timeouts
// R5: port reset cancels outstanding requests
// R6: drive link timeout value out
// R7: user timeout counts only while outstanding; the bench wt count runs from its call, outstanding or not
// R8: user keeps port idle during reset
// R9: port reset clears read and write tags
// R10: late responses after reset dropped silently
// R11: config clock equals logical clock
// R12: nonzero upper byte means remote, hop minus one
// R13: remote tags start zero, increment each
// R14: two low address bits ignored
// R15: address ready low while direction outstanding
`timescale 1ns/1ps
module mrt_tracker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic port_rst_i,
  input wire logic [31:0] link_timeout_i,
  output logic [31:0] link_timeout_o,
  // axi4-lite slave, user side
  input wire logic s_awvalid_i,
  input wire logic [mrt_pkg::ADDR_W-1:0] s_awaddr_i,
  input wire logic [2:0] s_awprot_i,
  output logic s_awready_o,
  input wire logic s_wvalid_i,
  input wire logic [mrt_pkg::DATA_W-1:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  output logic s_wready_o,
  output logic s_bvalid_o,
  output logic [1:0] s_bresp_o,
  input wire logic s_bready_i,
  input wire logic s_arvalid_i,
  input wire logic [mrt_pkg::ADDR_W-1:0] s_araddr_i,
  input wire logic [2:0] s_arprot_i,
  output logic s_arready_o,
  output logic s_rvalid_o,
  output logic [mrt_pkg::DATA_W-1:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  input wire logic s_rready_i,
  // request out, one per direction
  output logic wreq_valid_o,
  output mrt_pkg::mrt_req_t wreq_o,
  input wire logic wreq_ready_i,
  output logic rreq_valid_o,
  output mrt_pkg::mrt_req_t rreq_o,
  input wire logic rreq_ready_i,
  // responses back
  input wire logic wrsp_valid_i,
  input wire mrt_pkg::mrt_rsp_t wrsp_i,
  input wire logic rrsp_valid_i,
  input wire mrt_pkg::mrt_rsp_t rrsp_i
);
  localparam int TW = mrt_pkg::TAG_W;
  logic flush;
  logic aw_hs, w_hs, ar_hs;
  logic w_busy, w_issue, w_match, r_busy, r_issue, r_match;
  logic [TW-1:0] w_tag, r_tag;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [mrt_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [mrt_pkg::DATA_W-1:0] wdata_r, wdata_nxt;
  logic [mrt_pkg::ADDR_W-1:0] araddr_r, araddr_nxt;
  logic w_start, r_start, w_remote, r_remote, w_held_r, r_held_r;
  logic ar_got_r, ar_got_nxt;
  logic [TW-1:0] tid_r, tid_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [mrt_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [31:0] lto_r;

  // R4 port reset, same clock domain as the user master
  assign flush = port_rst_i;
  assign aw_hs = s_awvalid_i && awready_r;
  assign w_hs = s_wvalid_i && wready_r;
  assign ar_hs = s_arvalid_i && arready_r;
  // R12 upper byte nonzero routes remote
  assign w_remote = awaddr_r[mrt_pkg::HOP_MSB:mrt_pkg::HOP_LSB]
                    != mrt_pkg::HOP_LOCAL;
  assign r_remote = araddr_r[mrt_pkg::HOP_MSB:mrt_pkg::HOP_LSB]
                    != mrt_pkg::HOP_LOCAL;
  // R2 start only when both halves are captured and channel idle
  assign w_start = aw_got_r && w_got_r && !w_busy && !w_held_r;
  // read starts one cycle after capture, address held in araddr_r
  assign r_start = ar_got_r && !r_busy && !r_held_r;

  mrt_channel #(.TAG_W(TW)) u_wch (
    .clk_i(clk_i), .nrst_i(nrst_i), .flush_i(flush),
    .start_i(w_start), .remote_i(w_remote), .issued_i(wreq_ready_i),
    .rsp_valid_i(wrsp_valid_i), .rsp_tag_i(wrsp_i.tag), .tag_i(tid_r),
    .busy_o(w_busy), .issue_o(w_issue), .match_o(w_match), .tag_o(w_tag)
  );
  mrt_channel #(.TAG_W(TW)) u_rch (
    .clk_i(clk_i), .nrst_i(nrst_i), .flush_i(flush),
    .start_i(r_start), .remote_i(r_remote),
    .issued_i(rreq_ready_i), .rsp_valid_i(rrsp_valid_i),
    .rsp_tag_i(rrsp_i.tag), .tag_i(tid_r + TW'(w_start && w_remote)),
    .busy_o(r_busy), .issue_o(r_issue), .match_o(r_match), .tag_o(r_tag)
  );

  // request valids and tags from the channel flops, read data tied to zero, other fields from the capture registers
  always_comb begin
    wreq_valid_o = w_issue;
    wreq_o.remote = w_remote;
    wreq_o.hop = awaddr_r[mrt_pkg::HOP_MSB:mrt_pkg::HOP_LSB]
                 - mrt_pkg::HOP_ONE;
    // R14 low two offset bits forced to zero
    wreq_o.ofs = {awaddr_r[mrt_pkg::OFS_W-1:mrt_pkg::WORD_LSB], 2'h0};
    wreq_o.tag = w_tag;
    wreq_o.data = wdata_r;
    rreq_valid_o = r_issue;
    rreq_o.remote = r_remote;
    rreq_o.hop = araddr_r[mrt_pkg::HOP_MSB:mrt_pkg::HOP_LSB]
                 - mrt_pkg::HOP_ONE;
    rreq_o.ofs = {araddr_r[mrt_pkg::OFS_W-1:mrt_pkg::WORD_LSB], 2'h0};
    rreq_o.tag = r_tag;
    rreq_o.data = '0;
  end

  // capture and answer path; flush drops captured but unissued halves
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    ar_got_nxt = ar_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    araddr_nxt = araddr_r;
    tid_nxt = tid_r;
    bvalid_nxt = bvalid_r && !s_bready_i;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_rready_i;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (aw_hs) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_awaddr_i;
    end
    // R1 whole 32-bit word only, strobes are not honoured
    if (w_hs) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_wdata_i;
    end
    if (ar_hs) begin
      ar_got_nxt = 1'b1;
      araddr_nxt = s_araddr_i;
    end
    if (w_start) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
    end
    if (r_start) begin
      ar_got_nxt = 1'b0;
    end
    // R13 shared tag counter steps per remote request
    tid_nxt = tid_r + TW'(w_start && w_remote)
              + TW'(r_start && r_remote);
    // R3 only matching responses reach the user
    if (w_match) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = wrsp_i.resp;
    end
    if (r_match) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rrsp_i.resp;
      rdata_nxt = rrsp_i.data;
    end
    if (flush) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      ar_got_nxt = 1'b0;
    end
    // R15 address ready low while a direction is in flight
    // a channel that starts now is not busy yet, so its start counts too
    awready_nxt = !aw_got_nxt && !w_busy && !w_start && !bvalid_nxt
                  && !aw_hs;
    wready_nxt = !w_got_nxt && !w_busy && !w_start && !bvalid_nxt
                 && !w_hs;
    arready_nxt = !ar_got_nxt && !r_busy && !r_start && !rvalid_nxt
                  && !ar_hs;
  end

  // registers; held flags block restart until the answer is taken
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      ar_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      araddr_r <= '0;
      tid_r <= mrt_pkg::TAG_RST;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= mrt_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= mrt_pkg::RESP_OKAY;
      rdata_r <= '0;
      w_held_r <= 1'b0;
      r_held_r <= 1'b0;
      lto_r <= '0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      ar_got_r <= ar_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      araddr_r <= araddr_nxt;
      tid_r <= tid_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      w_held_r <= bvalid_nxt;
      r_held_r <= rvalid_nxt;
      // R6 timeout limit passed out registered
      lto_r <= link_timeout_i;
    end
  end

  assign s_awready_o = awready_r;
  assign s_wready_o = wready_r;
  assign s_arready_o = arready_r;
  assign s_bvalid_o = bvalid_r;
  assign s_bresp_o = bresp_r;
  assign s_rvalid_o = rvalid_r;
  assign s_rresp_o = rresp_r;
  assign s_rdata_o = rdata_r;
  assign link_timeout_o = lto_r;
endmodule

// ==== verilog/mrt_pkg.sv ====
// mrt_pkg: shared constants and carriers for the maintenance tracker
// assumes a 32-bit AXI4-Lite maintenance port and an 8-bit tag
package mrt_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int TAG_W = 8;
  localparam int OFS_W = 24;
  localparam int HOP_MSB = 31;
  localparam int HOP_LSB = 24;
  localparam int WORD_LSB = 2;
  localparam logic [7:0] HOP_LOCAL = 8'h00;
  localparam logic [7:0] HOP_ONE = 8'h01;
  localparam logic [TAG_W-1:0] TAG_RST = 8'h00;
  localparam logic [TAG_W-1:0] TAG_STEP = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [2:0] PROT_NONE = 3'h0;

  // request toward the configuration fabric or the serial link
  typedef struct packed {
    logic remote;
    logic [7:0] hop;
    logic [OFS_W-1:0] ofs;
    logic [TAG_W-1:0] tag;
    logic [DATA_W-1:0] data;
  } mrt_req_t;

  // response from the fabric or the link
  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [1:0] resp;
    logic [DATA_W-1:0] data;
  } mrt_rsp_t;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b001,
    CH_ISSUE = 3'b010,
    CH_WAIT = 3'b100
  } mrt_ch_state_t;
endpackage

// ==== verilog/mrt_channel.sv ====
// mrt_channel: one direction of the tracker, one request in flight
// assumes request inputs are in the clk_i domain and already captured
`timescale 1ns/1ps
module mrt_channel #(
  parameter int TAG_W = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic start_i,
  input wire logic remote_i,
  input wire logic issued_i,
  input wire logic rsp_valid_i,
  input wire logic [TAG_W-1:0] rsp_tag_i,
  input wire logic [TAG_W-1:0] tag_i,
  output logic busy_o,
  output logic issue_o,
  output logic match_o,
  output logic [TAG_W-1:0] tag_o
);
  mrt_pkg::mrt_ch_state_t st_r, st_nxt;
  logic [TAG_W-1:0] tag_r, tag_nxt;

  // tag width must fit the package reset constant
  if (TAG_W < 1 || TAG_W > mrt_pkg::TAG_W) begin : g_tag_w_bad
    $error("mrt_channel: TAG_W out of range");
  end

  // R3 R10 tag match, stale tags never match
  assign match_o = (st_r == mrt_pkg::CH_WAIT) && rsp_valid_i &&
                   (rsp_tag_i == tag_r) && !flush_i;
  assign busy_o = (st_r != mrt_pkg::CH_IDLE);
  assign issue_o = (st_r == mrt_pkg::CH_ISSUE);
  assign tag_o = tag_r;

  // next state; flush wins over everything
  always_comb begin
    st_nxt = st_r;
    tag_nxt = tag_r;
    unique case (st_r)
      mrt_pkg::CH_IDLE: begin
        if (start_i) begin
          st_nxt = mrt_pkg::CH_ISSUE;
          tag_nxt = tag_i;
        end
      end
      mrt_pkg::CH_ISSUE: begin
        if (issued_i) begin
          st_nxt = mrt_pkg::CH_WAIT;
        end
      end
      mrt_pkg::CH_WAIT: begin
        if (match_o) begin
          st_nxt = mrt_pkg::CH_IDLE;
        end
      end
      default: st_nxt = mrt_pkg::CH_IDLE;
    endcase
    // R5 R9 cancel and clear tag
    if (flush_i) begin
      st_nxt = mrt_pkg::CH_IDLE;
      tag_nxt = mrt_pkg::TAG_RST[TAG_W-1:0];
    end
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_r <= mrt_pkg::CH_IDLE;
      tag_r <= mrt_pkg::TAG_RST[TAG_W-1:0];
    end else begin
      st_r <= st_nxt;
      tag_r <= tag_nxt;
    end
  end
endmodule

// ==== verif/mrt_tracker_assertions.sv ====
// mrt_tracker_chk: port-level checks for the maintenance tracker
// assumes one clock clk_i and a synchronous active-low nrst_i
`timescale 1ns/1ps
module mrt_tracker_chk (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic port_rst_i,
  input wire logic [31:0] link_timeout_i,
  input wire logic [31:0] link_timeout_o,
  input wire logic s_awvalid_i,
  input wire logic s_awready_o,
  input wire logic s_bvalid_o,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic s_rvalid_o,
  input wire logic wreq_valid_o,
  input wire mrt_pkg::mrt_req_t wreq_o,
  input wire logic rreq_valid_o,
  input wire mrt_pkg::mrt_req_t rreq_o,
  input wire logic wrsp_valid_i,
  input wire logic rrsp_valid_i
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_timeout_copy: assert property ($past(nrst_i) |->
    link_timeout_o == $past(link_timeout_i)) else $error("timeout copy");
  chk_ar_hold: assert property (s_arvalid_i && s_arready_o |=>
    !s_arready_o until_with (s_rvalid_o || port_rst_i))
    else $error("ar ready early");
  chk_aw_hold: assert property (s_awvalid_i && s_awready_o |=>
    !s_awready_o until_with (s_bvalid_o || port_rst_i))
    else $error("aw ready early");
  chk_rd_answer: assert property ($rose(s_rvalid_o) |->
    $past(rrsp_valid_i) && !$past(port_rst_i)) else $error("stray rvalid");
  chk_wr_answer: assert property ($rose(s_bvalid_o) |->
    $past(wrsp_valid_i) && !$past(port_rst_i)) else $error("stray bvalid");
  chk_word_addr: assert property ((!rreq_valid_o ||
    rreq_o.ofs[1:0] == 2'h0) && (!wreq_valid_o || wreq_o.ofs[1:0] == 2'h0))
    else $error("low address bits kept");
  chk_rst_cancel: assert property (port_rst_i |=>
    !rreq_valid_o && !wreq_valid_o) else $error("request survived reset");
  chk_rst_drop: assert property (port_rst_i && !s_bvalid_o |=>
    !s_bvalid_o) else $error("answer after port reset");
endmodule

bind mrt_tracker mrt_tracker_chk u_chk (.*);

// ==== verif/mrt_fabric_model.sv ====
// mrt_fabric_model: fabric or link responder for one tracker direction
// assumes the tracker clock; answers dly_i cycles after taking a request
`timescale 1ns/1ps
module mrt_fabric_model (
  input wire logic clk_i,
  input wire logic req_valid_i,
  input wire mrt_pkg::mrt_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output mrt_pkg::mrt_rsp_t rsp_o,
  input wire logic [7:0] dly_i,
  input wire logic bad_i
);
  logic [7:0] cnt_r = 8'h00;
  mrt_pkg::mrt_rsp_t hold_r;
  // runs on the logic clock; one request at a time
  assign req_ready_o = cnt_r == 8'h00;
  initial begin
    rsp_o = '0;
    rsp_valid_o = 1'b0;
  end
  // idle cycles flip the data so a stale value never looks fresh
  always @(posedge clk_i) begin
    rsp_valid_o <= cnt_r == 8'h01;
    rsp_o <= (cnt_r == 8'h01) ? hold_r : ~rsp_o;
    if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    else if (req_valid_i) begin
      cnt_r <= dly_i;
      hold_r.tag <= req_i.tag ^ {8{bad_i}};
      // offset bit 2 asks for an error answer, so status is seen to pass
      hold_r.resp <= req_i.ofs[2] ? 2'h2 : mrt_pkg::RESP_OKAY;
      hold_r.data <= {8'h00, req_i.ofs} ^ 32'hA5A5A5A5;
    end
  end
endmodule

// ==== verif/mrt_tracker_bench.sv ====
// mrt_tracker_bench: self-checking bench for the maintenance tracker
// bench is the axi4-lite master; fabric models answer requests
`timescale 1ns/1ps
module mrt_tracker_bench;
  logic clk_i, nrst_i, port_rst_i, s_awvalid_i, s_wvalid_i, s_arvalid_i;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic wreq_valid_o, wreq_ready_i, rreq_valid_o, rreq_ready_i;
  logic wrsp_valid_i, rrsp_valid_i, rbad;
  logic s_bready_i = 1'b1;
  logic s_rready_i = 1'b1;
  logic [1:0] s_bresp_o, s_rresp_o, rsp_seen;
  logic [2:0] s_awprot_i = mrt_pkg::PROT_NONE;
  logic [2:0] s_arprot_i = mrt_pkg::PROT_NONE;
  logic [3:0] s_wstrb_i = 4'hF;
  logic [31:0] link_timeout_i, link_timeout_o, s_awaddr_i, s_wdata_i;
  logic [31:0] s_araddr_i, s_rdata_o, rdat;
  logic [7:0] rdly, wdly, tag_exp;
  mrt_pkg::mrt_req_t wreq_o, rreq_o, rlast, wlast;
  mrt_pkg::mrt_rsp_t wrsp_i, rrsp_i;
  int err_total, num_checks;

  mrt_tracker DUT (.*);
  mrt_fabric_model u_wfab (.clk_i(clk_i), .req_valid_i(wreq_valid_o),
    .req_i(wreq_o), .req_ready_o(wreq_ready_i), .rsp_valid_o(wrsp_valid_i),
    .rsp_o(wrsp_i), .dly_i(wdly), .bad_i(1'b0));
  mrt_fabric_model u_rfab (.clk_i(clk_i), .req_valid_i(rreq_valid_o),
    .req_i(rreq_o), .req_ready_o(rreq_ready_i), .rsp_valid_o(rrsp_valid_i),
    .rsp_o(rrsp_i), .dly_i(rdly), .bad_i(rbad));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // keep the last request each model took, for field checks
  always @(posedge clk_i) begin
    if (rreq_valid_o && rreq_ready_i) rlast <= rreq_o;
    if (wreq_valid_o && wreq_ready_i) wlast <= wreq_o;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return {8'h00, a[23:2], 2'h0} ^ 32'hA5A5A5A5;
  endfunction
  // valids held until ready is seen high at an edge
  task automatic issue(input bit rd, input logic [31:0] a, d);
    bit ka, kw;
    if (rd) s_arvalid_i = 1'b1;
    else {s_awvalid_i, s_wvalid_i} = 2'h3;
    s_araddr_i = rd ? a : s_araddr_i;
    s_awaddr_i = rd ? s_awaddr_i : a;
    s_wdata_i = rd ? s_wdata_i : d;
    for (int n = 0; n < 50; n++) begin
      ka = (rd ? s_arready_o : s_awready_o) === 1'b1;
      kw = s_wready_o === 1'b1;
      cyc(1);
      if (ka && rd) s_arvalid_i = 1'b0;
      if (ka && !rd) s_awvalid_i = 1'b0;
      if (kw && !rd) s_wvalid_i = 1'b0;
      if (!s_arvalid_i && !s_awvalid_i && !s_wvalid_i) return;
    end
    err_total++;
    final_report;
  endtask
  // the wait count runs from the call for up to lim cycles, outstanding access or not
  task automatic wt(input bit rd, input int lim, input bit must,
                    output bit got);
    got = 1'b0;
    for (int n = 0; n < lim && !got; n++) begin
      got = (rd ? s_rvalid_o : s_bvalid_o) === 1'b1;
      rdat = s_rdata_o;
      rsp_seen = rd ? s_rresp_o : s_bresp_o;
      cyc(1);
    end
    if (must && !got) begin
      err_total++;
      final_report;
    end
  endtask
  // the port stays idle while its reset is held
  task automatic prst(input int n);
    port_rst_i = 1'b1;
    cyc(n);
    port_rst_i = 1'b0;
  endtask

  task automatic t_local;
    bit got;
    link_timeout_i = 32'h00ABCDEF;
    issue(1, 32'h00000063, 32'h0);
    wt(1, 40, 1, got);
    chk(rlast.remote, 1'b0);
    chk(rlast.ofs, 24'h000060);
    chk(rdat, exp_rd(32'h00000063));
    chk(rsp_seen, mrt_pkg::RESP_OKAY);
    chk(link_timeout_o, 32'h00ABCDEF);
    $display("done local read");
  endtask
  task automatic t_remote;
    bit got;
    issue(0, 32'h03000106, 32'h12345678);
    wt(0, 40, 1, got);
    chk({wlast.remote, wlast.hop}, 9'h102);
    chk(wlast.tag, tag_exp);
    chk(wlast.ofs, 24'h000104);
    chk(wlast.data, 32'h12345678);
    chk(rsp_seen, 2'h2);
    issue(1, 32'hFF000010, 32'h0);
    wt(1, 40, 1, got);
    chk({rlast.remote, rlast.hop}, 9'h1FE);
    chk(rlast.tag, tag_exp + 8'h01);
    chk(rdat, exp_rd(32'hFF000010));
    $display("done remote");
  endtask
  task automatic t_busy;
    bit got;
    rdly = 8'h1E;
    issue(1, 32'h00000040, 32'h0);
    issue(0, 32'h00000044, 32'hCAFE0001);
    wt(0, 40, 1, got);
    chk(s_arready_o, 1'b0);
    wt(1, 60, 1, got);
    chk(rdat, exp_rd(32'h00000040));
    rdly = 8'h04;
    $display("done busy");
  endtask
  task automatic t_bad;
    bit got;
    rbad = 1'b1;
    issue(1, 32'h00000080, 32'h0);
    wt(1, 30, 0, got);
    chk(got, 1'b0);
    chk(s_arready_o, 1'b0);
    prst(2);
    rbad = 1'b0;
    issue(1, 32'h00000084, 32'h0);
    wt(1, 40, 0, got);
    chk(got, 1'b1);
    chk(rdat, exp_rd(32'h00000084));
    $display("done bad tag");
  endtask
  task automatic t_late;
    bit got;
    rdly = 8'h14;
    for (int i = 0; i < 2; i++) begin
      issue(1, 32'h00000100, 32'h0);
      cyc(4);
      prst(i == 0 ? 40 : 3);
      wt(1, 40, 0, got);
      chk(got, 1'b0);
    end
    rdly = 8'h04;
    $display("done late answer");
  endtask

  initial begin
    nrst_i = 1'b0;
    port_rst_i = 1'b0;
    {s_awvalid_i, s_wvalid_i, s_arvalid_i, rbad} = 4'h0;
    {s_awaddr_i, s_wdata_i, s_araddr_i} = '0;
    link_timeout_i = 32'h00012345;
    rdly = 8'h04;
    wdly = 8'h06;
    tag_exp = mrt_pkg::TAG_RST;
    cyc(12);
    nrst_i = 1'b1;
    cyc(2);
    t_local;
    t_remote;
    t_busy;
    t_bad;
    t_late;
    final_report;
  end
endmodule
